// ==== reset_state_initializer.sv ====
// Reset initialiser: vector fetch, state clearing and retention, AHB-Lite register slave
`include "reset_init_regs.svh"
`default_nettype none

// Overview of operation
// - Every reset loads PC 13..8 from word 0 bits 5..0, PC 7..0 from word 1.
// - Every reset loads register bank enable from word 0 bit 6, memory bank bit 7.
// - Every reset clears the three skip flags.
// - Every reset clears both interrupt status flags.
// - General registers kept on standby reset, scrubbed on reset during operation.
// - Pulse generator modulo high and low registers are kept on every reset.
// - Every reset clears the event gate control register.
// - Serial 0 shift register kept on standby reset, scrubbed otherwise.
// - Every reset clears the serial bus control register.
// - Serial slave address kept on standby reset, scrubbed otherwise.
// - Every reset clears the serial 1 transfer done flag.
// - Output buffers are off while the reset input is asserted.
module reset_state_initializer #(
	parameter int GATE_W = 4
) (
	input  wire logic                 mclk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic                 dev_reset_n_i,
	input  wire logic                 ser1_done_i,
	output logic      [13:0]          pmem_addr_o,
	output logic                      pmem_rd_o,
	input  wire logic [7:0]           pmem_data_i,
	output reset_init_pkg::vector_type vector_o,
	output reset_init_pkg::psw_type    psw_o,
	output logic                      core_ready_o,
	output logic                      out_buf_en_o,
	output logic                      standby_o,
	input  wire logic                 hsel_i,
	input  wire logic [31:0]          haddr_i,
	input  wire logic [1:0]           htrans_i,
	input  wire logic                 hwrite_i,
	input  wire logic [2:0]           hsize_i,
	input  wire logic [31:0]          hwdata_i,
	input  wire logic                 hready_i,
	output logic                      hreadyout_o,
	output logic [31:0]               hrdata_o,
	output logic                      hresp_o
);
	import reset_init_pkg::*;

	fetch_state_type   state_ff;
	fetch_state_type   nxt_state;
	vector_type        vec_ff;
	psw_type           psw_ff;
	logic              rst_meta_ff;
	logic              dev_rst_ff;
	logic              dev_rst_prev_ff;
	logic              rst_rise;
	logic              standby_ff;
	logic              standby_at_reset_ff;
	logic              lose;
	logic [13:0]       pmem_addr_ff;
	logic              pmem_rd_ff;
	logic [GATE_W-1:0] gate_ff;
	logic [7:0]        sbc_ff;
	logic              done1_ff;
	logic [31:0]       gpr_q;
	logic [7:0]        shift0_q;
	logic [7:0]        slv_addr_q;
	logic [15:0]       mod_q;
	logic              ap_fire;
	logic              wr_pend_ff;
	logic              rd_pend_ff;
	logic [7:0]        ap_addr_ff;
	logic              wr_fire;
	logic [31:0]       hrdata_ff;
	logic [31:0]       rd_mux;

	// Reset pin crosses in through two flops; stored as active high
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			rst_meta_ff     <= 1'b1;
			dev_rst_ff      <= 1'b1;
			dev_rst_prev_ff <= 1'b1;
		end
		else
		begin
			rst_meta_ff     <= ~dev_reset_n_i;
			dev_rst_ff      <= rst_meta_ff;
			dev_rst_prev_ff <= dev_rst_ff;
		end
	end

	assign rst_rise = dev_rst_ff & ~dev_rst_prev_ff;
	assign lose     = rst_rise & ~standby_ff;

	// Standby is left by the reset that ends it, in the same cycle its state is recorded
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			standby_ff          <= 1'b0;
			standby_at_reset_ff <= 1'b0;
		end
		else if (rst_rise)
		begin
			standby_at_reset_ff <= standby_ff;
			standby_ff          <= 1'b0;
		end
		else if (wr_fire && ap_addr_ff == `RI_OFF_STBY)
			standby_ff <= hwdata_i[`RI_STBY_BIT];
	end

	// Vector fetch sequence, restarted by every reset
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_HOLD: if (!dev_rst_ff) nxt_state = ST_RD0;
			ST_RD0:  nxt_state = ST_CAP0;
			ST_CAP0: nxt_state = ST_CAP1;
			ST_CAP1: nxt_state = ST_RUN;
			ST_RUN:  nxt_state = ST_RUN;
		endcase
		if (dev_rst_ff)
			nxt_state = ST_HOLD;
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			state_ff <= ST_HOLD;
		else
			state_ff <= nxt_state;
	end

	// Memory sees its address one cycle before the data comes back
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || dev_rst_ff)
		begin
			pmem_rd_ff   <= 1'b0;
			pmem_addr_ff <= `RI_VEC_ADDR0;
		end
		else if (state_ff == ST_HOLD)
		begin
			pmem_rd_ff   <= 1'b1;
			pmem_addr_ff <= `RI_VEC_ADDR0;
		end
		else if (state_ff == ST_RD0)
			pmem_addr_ff <= `RI_VEC_ADDR1;
		else if (state_ff == ST_CAP0)
			pmem_rd_ff <= 1'b0;
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			vec_ff <= '0;
		else if (state_ff == ST_CAP0)
		begin
			vec_ff.pc[13:8] <= pmem_data_i[`RI_W0_PCHI_MSB:0];
			vec_ff.register_bank_enable_flag <= pmem_data_i[`RI_W0_RBE_BIT];
			vec_ff.memory_bank_enable_flag   <= pmem_data_i[`RI_W0_MBE_BIT];
		end
		else if (state_ff == ST_CAP1)
			vec_ff.pc[7:0] <= pmem_data_i;
	end

	// Flags and control registers cleared for as long as reset is held
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || dev_rst_ff)
			psw_ff <= '0;
		else if (wr_fire && ap_addr_ff == `RI_OFF_PSW)
			psw_ff <= hwdata_i[4:0];
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || dev_rst_ff)
			gate_ff <= '0;
		else if (wr_fire && ap_addr_ff == `RI_OFF_GATE)
			gate_ff <= hwdata_i[GATE_W-1:0];
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || dev_rst_ff)
			sbc_ff <= '0;
		else if (wr_fire && ap_addr_ff == `RI_OFF_SBC)
			sbc_ff <= hwdata_i[7:0];
	end

	// A completion in the same cycle as a software clear is kept
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || dev_rst_ff)
			done1_ff <= 1'b0;
		else if (ser1_done_i)
			done1_ff <= 1'b1;
		else if (wr_fire && ap_addr_ff == `RI_OFF_DONE1 && hwdata_i[`RI_DONE1_BIT])
			done1_ff <= 1'b0;
	end

	retain_reg #(.WIDTH(32), .FILL(`RI_LOSE_FILL)) u_gpr (
		.mclk_i   (mclk_i),
		.sys_rst_i(sys_rst_i),
		.lose_i   (lose),
		.wr_i     (wr_fire && ap_addr_ff == `RI_OFF_GPR),
		.wdata_i  (hwdata_i),
		.q_o      (gpr_q)
	);

	retain_reg #(.WIDTH(8), .FILL(`RI_LOSE_FILL)) u_shift0 (
		.mclk_i   (mclk_i),
		.sys_rst_i(sys_rst_i),
		.lose_i   (lose),
		.wr_i     (wr_fire && ap_addr_ff == `RI_OFF_SHIFT0),
		.wdata_i  (hwdata_i[7:0]),
		.q_o      (shift0_q)
	);

	retain_reg #(.WIDTH(8), .FILL(`RI_LOSE_FILL)) u_slv_addr (
		.mclk_i   (mclk_i),
		.sys_rst_i(sys_rst_i),
		.lose_i   (lose),
		.wr_i     (wr_fire && ap_addr_ff == `RI_OFF_SLVADR),
		.wdata_i  (hwdata_i[7:0]),
		.q_o      (slv_addr_q)
	);

	retain_reg #(.WIDTH(16), .FILL(`RI_LOSE_FILL)) u_mod (
		.mclk_i   (mclk_i),
		.sys_rst_i(sys_rst_i),
		.lose_i   (1'b0),
		.wr_i     (wr_fire && ap_addr_ff == `RI_OFF_MOD),
		.wdata_i  (hwdata_i[15:0]),
		.q_o      (mod_q)
	);

	// Bus slave: writes without wait, reads with one wait state so data leave a flop
	assign ap_fire = hsel_i && htrans_i[1] && hready_i;
	assign wr_fire = wr_pend_ff;

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			ap_addr_ff <= 8'h00;
		end
		else
		begin
			wr_pend_ff <= ap_fire && hwrite_i;
			rd_pend_ff <= ap_fire && !hwrite_i;
			if (ap_fire)
				ap_addr_ff <= haddr_i[7:0];
		end
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (ap_addr_ff)
			`RI_OFF_STATUS: rd_mux = {10'h000, vec_ff.pc, 3'h0, vec_ff.memory_bank_enable_flag,
				vec_ff.register_bank_enable_flag, dev_rst_ff, standby_at_reset_ff, core_ready_o};
			`RI_OFF_PSW:    rd_mux = {27'h0000000, psw_ff};
			`RI_OFF_GPR:    rd_mux = gpr_q;
			`RI_OFF_MOD:    rd_mux = {16'h0000, mod_q};
			`RI_OFF_GATE:   rd_mux = {{(32-GATE_W){1'b0}}, gate_ff};
			`RI_OFF_SHIFT0: rd_mux = {24'h000000, shift0_q};
			`RI_OFF_SBC:    rd_mux = {24'h000000, sbc_ff};
			`RI_OFF_SLVADR: rd_mux = {24'h000000, slv_addr_q};
			`RI_OFF_DONE1:  rd_mux = {31'h00000000, done1_ff};
			`RI_OFF_STBY:   rd_mux = {31'h00000000, standby_ff};
			default:        rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			hrdata_ff <= `RI_RST_ZERO;
		else if (rd_pend_ff)
			hrdata_ff <= rd_mux;
	end

	assign hreadyout_o  = ~rd_pend_ff;
	assign hrdata_o     = hrdata_ff;
	assign hresp_o      = 1'b0;
	assign pmem_addr_o  = pmem_addr_ff;
	assign pmem_rd_o    = pmem_rd_ff;
	assign vector_o     = vec_ff;
	assign psw_o        = psw_ff;
	assign standby_o    = standby_ff;
	assign core_ready_o = (state_ff == ST_RUN);
	// Gated by the synced level too, so buffers drop the cycle reset is seen
	assign out_buf_en_o = core_ready_o & ~dev_rst_ff;

	property p_pc_high;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(state_ff == ST_CAP0) |=> (vec_ff.pc[13:8] == $past(pmem_data_i[5:0]));
	endproperty
	a_pc_high: assert property (p_pc_high) else $error("PC high bits not from word 0");

	property p_pc_low;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(state_ff == ST_CAP1 && !dev_rst_ff) |=> (vec_ff.pc[7:0] == $past(pmem_data_i))
			&& core_ready_o;
	endproperty
	a_pc_low: assert property (p_pc_low) else $error("PC low bits not from word 1");

	property p_bank_flags;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(state_ff == ST_CAP0) |=> (vec_ff.register_bank_enable_flag == $past(pmem_data_i[6])
			&& vec_ff.memory_bank_enable_flag == $past(pmem_data_i[7]));
	endproperty
	a_bank_flags: assert property (p_bank_flags) else $error("Bank flags not from word 0");

	property p_skip_clr;
		@(posedge mclk_i) disable iff (sys_rst_i)
		dev_rst_ff |=> (psw_ff.skip_flag_zero == 1'b0 && psw_ff.skip_flag_one == 1'b0
			&& psw_ff.skip_flag_two == 1'b0);
	endproperty
	a_skip_clr: assert property (p_skip_clr) else $error("Skip flags not cleared");

	property p_ist_clr;
		@(posedge mclk_i) disable iff (sys_rst_i)
		dev_rst_ff |=> !psw_ff.int_status_flag_one && !psw_ff.int_status_flag_two;
	endproperty
	a_ist_clr: assert property (p_ist_clr) else $error("Interrupt status not cleared");

	property p_gpr_keep;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(rst_rise && standby_ff && !wr_fire) |=> $stable(gpr_q);
	endproperty
	a_gpr_keep: assert property (p_gpr_keep) else $error("GPR lost on standby reset");

	property p_gpr_lose;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(rst_rise && !standby_ff) |=> (gpr_q == `RI_LOSE_FILL);
	endproperty
	a_gpr_lose: assert property (p_gpr_lose) else $error("GPR not scrubbed");

	property p_mod_keep;
		@(posedge mclk_i) disable iff (sys_rst_i)
		(dev_rst_ff && !wr_fire) |=> $stable(mod_q);
	endproperty
	a_mod_keep: assert property (p_mod_keep) else $error("Modulo registers changed on reset");

	property p_gate_clr;
		@(posedge mclk_i) disable iff (sys_rst_i)
		dev_rst_ff[*2] |-> (gate_ff == '0);
	endproperty
	a_gate_clr: assert property (p_gate_clr) else $error("Gate control not cleared");

	property p_shift0_lose;
		@(posedge mclk_i) disable iff (sys_rst_i)
		rst_rise |=> (shift0_q == ($past(standby_ff) ? $past(shift0_q) : 8'hA5));
	endproperty
	a_shift0_lose: assert property (p_shift0_lose) else $error("Shift register policy wrong");

	property p_sbc_clr;
		@(posedge mclk_i) disable iff (sys_rst_i)
		dev_rst_ff |=> (sbc_ff == 8'h00);
	endproperty
	a_sbc_clr: assert property (p_sbc_clr) else $error("Serial bus control not cleared");

	property p_slv_addr_lose;
		@(posedge mclk_i) disable iff (sys_rst_i)
		rst_rise |=> (slv_addr_q == ($past(standby_ff) ? $past(slv_addr_q) : 8'hA5));
	endproperty
	a_slv_addr_lose: assert property (p_slv_addr_lose) else $error("Slave address policy wrong");

	property p_done1_clr;
		@(posedge mclk_i) disable iff (sys_rst_i)
		dev_rst_ff |=> !done1_ff;
	endproperty
	a_done1_clr: assert property (p_done1_clr) else $error("Transfer done flag not cleared");

	property p_buf_off;
		@(posedge mclk_i) disable iff (sys_rst_i)
		dev_rst_ff |-> !out_buf_en_o ##1 !out_buf_en_o;
	endproperty
	a_buf_off: assert property (p_buf_off) else $error("Output buffer on during reset");

	property p_stby_rec;
		@(posedge mclk_i) disable iff (sys_rst_i)
		rst_rise |=> (standby_at_reset_ff == $past(standby_ff)) && !standby_ff;
	endproperty
	a_stby_rec: assert property (p_stby_rec) else $error("Standby at reset not recorded");

endmodule : reset_state_initializer
`default_nettype wire

// ==== reset_init_regs.svh ====
// Register offsets, field positions, reset values and vector addresses of the reset initialiser
`ifndef RESET_INIT_REGS_SVH
`define RESET_INIT_REGS_SVH

`define RI_OFF_STATUS   8'h00
`define RI_OFF_PSW      8'h04
`define RI_OFF_GPR      8'h08
`define RI_OFF_MOD      8'h0C
`define RI_OFF_GATE     8'h10
`define RI_OFF_SHIFT0   8'h14
`define RI_OFF_SBC      8'h18
`define RI_OFF_SLVADR   8'h1C
`define RI_OFF_DONE1    8'h20
`define RI_OFF_STBY     8'h24

`define RI_VEC_ADDR0    14'h0000
`define RI_VEC_ADDR1    14'h0001
`define RI_W0_PCHI_MSB  5
`define RI_W0_RBE_BIT   6
`define RI_W0_MBE_BIT   7

`define RI_RST_ZERO     32'h0000_0000
`define RI_LOSE_FILL    32'hA5A5_A5A5
`define RI_DONE1_BIT    0
`define RI_STBY_BIT     0

`endif

// ==== reset_init_pkg.sv ====
// Types shared by the reset initialiser
`default_nettype none
package reset_init_pkg;

	typedef enum logic [4:0]
	{
		ST_HOLD = 5'b00001,
		ST_RD0  = 5'b00010,
		ST_CAP0 = 5'b00100,
		ST_CAP1 = 5'b01000,
		ST_RUN  = 5'b10000
	} fetch_state_type;

	typedef struct packed
	{
		logic        memory_bank_enable_flag;
		logic        register_bank_enable_flag;
		logic [13:0] pc;
	} vector_type;

	typedef struct packed
	{
		logic int_status_flag_two;
		logic int_status_flag_one;
		logic skip_flag_two;
		logic skip_flag_one;
		logic skip_flag_zero;
	} psw_type;

endpackage : reset_init_pkg
`default_nettype wire

// ==== retain_reg.sv ====
// Storage that survives a device reset in standby and is scrubbed otherwise
`default_nettype none
module retain_reg #(
	parameter int          WIDTH = 8,
	parameter logic [31:0] FILL  = 32'hA5A5_A5A5
) (
	input  wire logic             mclk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             lose_i,
	input  wire logic             wr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] q_ff;

	// Lost contents are forced to a visible pattern rather than left as is
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			q_ff <= '0;
		else if (lose_i)
			q_ff <= FILL[WIDTH-1:0];
		else if (wr_i)
			q_ff <= wdata_i;
	end

	assign q_o = q_ff;

endmodule : retain_reg
`default_nettype wire

// ==== reset_state_initializer_bench.sv ====
// Self-checking bench for the reset state initialiser
`include "reset_init_regs.svh"
`default_nettype none
`define CHK(got, exp) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) \
		begin \
			err_total++; \
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
		end \
	end

module reset_state_initializer_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                              mclk_i = 1'h0;
	logic                              sys_rst_i;
	logic                              dev_reset_n_i;
	logic                              ser1_done_i;
	logic        [13:0]                pmem_addr_o;
	logic                              pmem_rd_o;
	logic        [7:0]                 pmem_data_i;
	reset_init_pkg::vector_type        vector_o;
	reset_init_pkg::psw_type           psw_o;
	logic                              core_ready_o;
	logic                              out_buf_en_o;
	logic                              standby_o;
	logic                              hsel_i;
	logic        [31:0]                haddr_i;
	logic        [1:0]                 htrans_i;
	logic                              hwrite_i;
	logic        [2:0]                 hsize_i;
	logic        [31:0]                hwdata_i;
	wire logic                         hready_i;
	logic                              hreadyout_o;
	logic        [31:0]                hrdata_o;
	logic                              hresp_o;
	int                                err_total;
	int                                cmp_count;
	int                                cyc;
	logic        [7:0]                 w0;
	logic        [7:0]                 w1;
	logic        [13:0]                a_s;
	logic                              r_s;
	logic        [31:0]                d;
	logic        [7:0]                 offs [7] = '{`RI_OFF_PSW, `RI_OFF_GPR, `RI_OFF_MOD,
		`RI_OFF_GATE, `RI_OFF_SHIFT0, `RI_OFF_SBC, `RI_OFF_SLVADR};
	logic        [31:0]                vals [7] = '{32'h0000_001F, 32'h1234_5678,
		32'h0000_BEEF, 32'h0000_000F, 32'h0000_005A, 32'h0000_0077, 32'h0000_003C};

	// Single slave, so its ready is the bus ready
	assign hready_i = hreadyout_o;

	always #20 mclk_i = ~mclk_i;

	reset_state_initializer #(.GATE_W(4)) dut (
		.mclk_i        (mclk_i),
		.sys_rst_i     (sys_rst_i),
		.dev_reset_n_i (dev_reset_n_i),
		.ser1_done_i   (ser1_done_i),
		.pmem_addr_o   (pmem_addr_o),
		.pmem_rd_o     (pmem_rd_o),
		.pmem_data_i   (pmem_data_i),
		.vector_o      (vector_o),
		.psw_o         (psw_o),
		.core_ready_o  (core_ready_o),
		.out_buf_en_o  (out_buf_en_o),
		.standby_o     (standby_o),
		.hsel_i        (hsel_i),
		.haddr_i       (haddr_i),
		.htrans_i      (htrans_i),
		.hwrite_i      (hwrite_i),
		.hsize_i       (hsize_i),
		.hwdata_i      (hwdata_i),
		.hready_i      (hready_i),
		.hreadyout_o   (hreadyout_o),
		.hrdata_o      (hrdata_o),
		.hresp_o       (hresp_o)
	);

	// Program memory: sample the request mid-cycle to stay clear of the edge race
	always @(negedge mclk_i)
	begin
		a_s = pmem_addr_o;
		r_s = pmem_rd_o;
	end

	// Outside a read the data toggles, so a stale capture cannot pass
	always @(posedge mclk_i)
		pmem_data_i <= r_s ? ((a_s == `RI_VEC_ADDR1) ? w1 : w0) : ~pmem_data_i;

	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			$display("wrong value at %0t: run hung", $time);
			results();
		end
	end

	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	// Ready is looked at mid-cycle; it only moves after rising edges
	task automatic wait_rdy(output logic [31:0] rd);
		logic r;
		do
		begin
			@(negedge mclk_i);
			r = hreadyout_o;
			rd = hrdata_o;
			@(posedge mclk_i);
		end
		while (r !== 1'h1);
	endtask : wait_rdy

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel_i <= 1'h1;
		haddr_i <= {24'h000000, a};
		htrans_i <= 2'h2;
		hwrite_i <= wr;
		hsize_i <= 3'h2;
		wait_rdy(rd);
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		wait_rdy(rd);
	endtask : ahb

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		ahb(1'h0, a, 32'h0000_0000, rd);
		`CHK(rd, exp)
		`CHK(hresp_o, 1'h0)
	endtask : rd_chk

	task automatic wait_core;
		int n;
		n = 0;
		do
		begin
			@(negedge mclk_i);
			n++;
		end
		while (core_ready_o !== 1'h1 && n < 60);
		`CHK(core_ready_o, 1'h1)
		@(posedge mclk_i);
	endtask : wait_core

	task automatic pulse_done;
		ser1_done_i <= 1'h1;
		@(posedge mclk_i);
		ser1_done_i <= 1'h0;
		@(posedge mclk_i);
	endtask : pulse_done

	task automatic load_regs;
		for (int i = 0; i < 7; i++)
			ahb(1'h1, offs[i], vals[i], d);
		pulse_done();
	endtask : load_regs

	task automatic dev_reset(input logic [7:0] n0, input logic [7:0] n1);
		w0 <= n0;
		w1 <= n1;
		dev_reset_n_i <= 1'h0;
		repeat (8) @(posedge mclk_i);
		@(negedge mclk_i);
		`CHK(out_buf_en_o, 1'h0)
		`CHK(core_ready_o, 1'h0)
		@(posedge mclk_i);
		dev_reset_n_i <= 1'h1;
		wait_core();
		`CHK(psw_o, 5'h00)
	endtask : dev_reset

	task automatic check_all(input logic keep);
		rd_chk(`RI_OFF_PSW, 32'h0000_0000);
		rd_chk(`RI_OFF_GPR, keep ? 32'h1234_5678 : 32'hA5A5_A5A5);
		rd_chk(`RI_OFF_MOD, 32'h0000_BEEF);
		rd_chk(`RI_OFF_GATE, 32'h0000_0000);
		rd_chk(`RI_OFF_SHIFT0, keep ? 32'h0000_005A : 32'h0000_00A5);
		rd_chk(`RI_OFF_SBC, 32'h0000_0000);
		rd_chk(`RI_OFF_SLVADR, keep ? 32'h0000_003C : 32'h0000_00A5);
		rd_chk(`RI_OFF_DONE1, 32'h0000_0000);
	endtask : check_all

	initial
	begin
		err_total = 0;
		cmp_count = 0;
		cyc = 0;
		w0 = 8'hC5;
		w1 = 8'h3A;
		sys_rst_i = 1'h1;
		dev_reset_n_i = 1'h1;
		ser1_done_i = 1'h0;
		hsel_i = 1'h0;
		haddr_i = 32'h0000_0000;
		htrans_i = 2'h0;
		hwrite_i = 1'h0;
		hsize_i = 3'h2;
		hwdata_i = 32'h0000_0000;
		repeat (12) @(posedge mclk_i);
		sys_rst_i <= 1'h0;
		wait_core();
		`CHK(vector_o, {1'h1, 1'h1, 14'h053A})
		`CHK(psw_o, 5'h00)
		`CHK(out_buf_en_o, 1'h1)
		rd_chk(`RI_OFF_STATUS, {10'h000, 14'h053A, 3'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1});
		load_regs();
		rd_chk(`RI_OFF_PSW, 32'h0000_001F);
		rd_chk(`RI_OFF_DONE1, 32'h0000_0001);
		ahb(1'h1, `RI_OFF_DONE1, 32'h0000_0001, d);
		rd_chk(`RI_OFF_DONE1, 32'h0000_0000);
		ahb(1'h1, 8'h28, 32'hFFFF_FFFF, d);
		rd_chk(8'h28, 32'h0000_0000);
		pulse_done();
		// Reset during operation: scrubbed storage shows the fill pattern
		dev_reset(8'h2A, 8'h81);
		`CHK(vector_o, {1'h0, 1'h0, 14'h2A81})
		check_all(1'h0);
		rd_chk(`RI_OFF_STATUS, {10'h000, 14'h2A81, 3'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1});
		// Reset in standby: retained storage survives
		load_regs();
		ahb(1'h1, `RI_OFF_STBY, 32'h0000_0001, d);
		// The write lands on the edge the task returns at, so look mid-cycle
		@(negedge mclk_i);
		`CHK(standby_o, 1'h1)
		@(posedge mclk_i);
		dev_reset(8'h40, 8'hFF);
		`CHK(vector_o, {1'h0, 1'h1, 14'h00FF})
		`CHK(standby_o, 1'h0)
		check_all(1'h1);
		rd_chk(`RI_OFF_STATUS, {10'h000, 14'h00FF, 3'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1});
		results();
	end
endmodule : reset_state_initializer_bench
`default_nettype wire
